// ===== rtl/cmd_bridge_pkg.sv
// shared constants for the command link between host controller and bridge device
package cmd_bridge_pkg;
  localparam logic [7:0] CODE_PAGE_WRITE = 8'h96;
  localparam logic [7:0] CODE_PAGE_READ  = 8'h44;
  localparam logic [7:0] CODE_STATUS     = 8'haa;
  localparam logic [7:0] CODE_SET_ADDR   = 8'h75;
  localparam logic [7:0] RES_OK          = 8'haa;
  localparam logic [7:0] RES_PROTECTED   = 8'h55;
  localparam logic [7:0] RES_INVALID     = 8'h77;
  localparam logic [7:0] FILL_BYTE       = 8'hff;
  localparam logic [7:0] PAGE_WRITE_LEN  = 8'h21;
  localparam logic [7:0] PARAM_ONLY_LEN  = 8'h01;
  localparam logic [7:0] PAGE_READ_RLEN  = 8'h21;
  localparam logic [7:0] STATUS_PROT_RLEN = 8'h07;
  localparam logic [7:0] STATUS_ID_RLEN  = 8'h03;
  localparam logic [7:0] SHORT_RLEN      = 8'h01;
  localparam int         PAGE_BYTES      = 32;
  localparam logic [2:0] PAGE_COUNT      = 3'h6;
  localparam logic [6:0] FIRST_DATA      = 7'h03;
  localparam int         PROT_WP_BIT     = 1;
  localparam int         PROT_NONE_BIT   = 5;
  localparam logic [1:0] SEL_PROT        = 2'h0;
  localparam logic [1:0] SEL_MAKER       = 2'h1;
  localparam logic [1:0] SEL_VERSION     = 2'h2;
  localparam logic [6:0] DEFAULT_ADDR_RST = 7'h20;
  localparam int         CLK_PERIOD_NS   = 50;
  localparam int         PAGE_WRITE_DURATION_NS = 5000;
  localparam int         PAGE_READ_DURATION_NS  = 1000;
  localparam int         ADDR_SET_DURATION_NS   = 5000;
  localparam logic [15:0] PAGE_WRITE_CYCLES =
    16'((PAGE_WRITE_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] PAGE_READ_CYCLES =
    16'((PAGE_READ_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] ADDR_SET_CYCLES =
    16'((ADDR_SET_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_PARAM    = 8'h04;
  localparam logic [7:0] REG_DATA     = 8'h08;
  localparam logic [7:0] REG_PTR      = 8'h0c;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // processing time of a command, shared so both ends agree on it
  function automatic logic [15:0] duration_cycles(input logic [7:0] code);
    if (code == CODE_PAGE_WRITE) begin
      return PAGE_WRITE_CYCLES;
    end else if (code == CODE_SET_ADDR) begin
      return ADDR_SET_CYCLES;
    end else begin
      return PAGE_READ_CYCLES;
    end
  endfunction
endpackage

// ===== rtl/cmd_link.sv
// byte-stream carrier between host controller and bridge device
`timescale 1ns/1ps
interface cmd_link;
  logic       cmd_valid;
  logic       cmd_ready;
  logic [7:0] cmd_data;
  logic       cmd_last;
  logic       rsp_valid;
  logic       rsp_ready;
  logic [7:0] rsp_data;
  logic       rsp_last;
  modport device (input cmd_valid, cmd_data, cmd_last, rsp_ready,
                  output cmd_ready, rsp_valid, rsp_data, rsp_last);
  modport host   (output cmd_valid, cmd_data, cmd_last, rsp_ready,
                  input cmd_ready, rsp_valid, rsp_data, rsp_last);
endinterface // cmd_link

// ===== rtl/page_store.sv
// user page memory: one write port, combinational read port
`timescale 1ns/1ps
module page_store #(
  parameter int DEPTH = 192,
  parameter int AW    = 8
) (
  input  wire logic          aclk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  // no reset: contents are nonvolatile in spirit and odd pages read as whatever is held
  logic [7:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule // page_store

// ===== rtl/bridge_device.sv
// device end: takes command frames, executes them, returns length, result and data
// Behaviour
// - page write frame: code, 33, page, 32 bytes
// - page read returns 32 bytes, result AAh
// - invalid page read: 32 bytes FFh, result 77h
// - odd page read succeeds, data variable
// - page number in bits 2:0, 0 to 5
// - page read frame length 1; reply length 33
// - status: protection, maker id or version
// - status select 00 prot, 01 maker, 10 version
// - maker identifier sent high byte first
// - status reply length 7 or 3
// - protection byte bit 1 marks write protection
// - protection byte bit 5 marks protection lockout
// - first address change stored, result AAh
// - later address change fails with 55h
// - new address held in bits 7:1
// - reply opens with length then result byte
// - write to protected page fails with 55h
`timescale 1ns/1ps
module bridge_device
  import cmd_bridge_pkg::*;
#(
  parameter logic [15:0] MAKER_ID     = 16'h5a3c, // arbitrary value
  parameter logic [15:0] VERSION_ID   = 16'h0101, // arbitrary value
  parameter logic [6:0]  DEFAULT_ADDR = DEFAULT_ADDR_RST,
  parameter logic [5:0]  NONE_LOCK    = 6'h00
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  cmd_link.device         lnk,
  output logic      [6:0] dev_addr,
  output logic            addr_locked
);
  typedef enum logic [1:0] {D_RX, D_EXEC, D_TX} dev_state_type;

  dev_state_type state_r;
  logic [7:0]    code_r;
  logic [7:0]    len_r;
  logic [7:0]    param_r;
  logic [7:0]    res_r;
  logic [7:0]    rlen_r;
  logic [6:0]    cnt_r;
  logic [15:0]   wait_r;
  logic [5:0]    idx_r;
  logic          fill_r;
  logic          cmd_ready_r;
  logic          rsp_valid_r;
  logic          rsp_last_r;
  logic [7:0]    rsp_data_r;
  logic          cmd_hs;
  logic          rsp_hs;
  logic [2:0]    page;
  logic          page_ok;
  logic          frame_ok;
  logic          mem_we;
  logic [6:0]    wr_k;
  logic [5:0]    rd_k;
  logic [7:0]    mem_rd;
  logic [7:0]    tx_byte;
  logic [7:0]    res_nxt;
  logic [7:0]    rlen_nxt;
  logic          fill_nxt;
  logic          take_addr;
  logic          tx_last;

  assign lnk.cmd_ready = cmd_ready_r;
  assign lnk.rsp_valid = rsp_valid_r;
  assign lnk.rsp_data  = rsp_data_r;
  assign lnk.rsp_last  = rsp_last_r;

  assign cmd_hs   = ce && lnk.cmd_valid && cmd_ready_r;
  assign rsp_hs   = ce && rsp_valid_r && lnk.rsp_ready;
  assign page     = param_r[2:0];
  assign page_ok  = (param_r[7:3] == 5'h00) && (page < PAGE_COUNT);
  assign frame_ok = {2'h0, cnt_r} == ({1'b0, len_r} + 9'h002);
  assign wr_k     = cnt_r - FIRST_DATA;
  assign rd_k     = idx_r - 6'h02;
  assign tx_last  = idx_r == rlen_r[5:0];

  // protection is decided before any data byte lands, so a refused write never
  // touches memory; a truncated frame to a writable page may leave a partial page
  assign mem_we = cmd_hs && (code_r == CODE_PAGE_WRITE) && (len_r == PAGE_WRITE_LEN)
                  && page_ok && !page[0] && (cnt_r >= FIRST_DATA)
                  && (wr_k < 7'(PAGE_BYTES));

  page_store #(
    .DEPTH (32'(PAGE_COUNT) * PAGE_BYTES),
    .AW    (8)
  ) u_store (
    .aclk  (aclk),
    .ce    (ce),
    .we    (mem_we),
    .waddr ({page, wr_k[4:0]}),
    .wdata (lnk.cmd_data),
    .raddr ({page, rd_k[4:0]}),
    .rdata (mem_rd)
  );

  function automatic logic [7:0] prot_byte(input logic [2:0] pg);
    logic [7:0] b;
    b = 8'h00;
    if (pg[0]) begin
      b[PROT_WP_BIT] = 1'b1;
    end else if (NONE_LOCK[pg]) begin
      b[PROT_NONE_BIT] = 1'b1;
    end
    return b;
  endfunction

  // outcome of the frame, evaluated when the processing delay runs out
  always_comb begin
    res_nxt   = RES_INVALID;
    rlen_nxt  = SHORT_RLEN;
    fill_nxt  = 1'b1;
    take_addr = 1'b0;
    case (code_r)
      CODE_PAGE_WRITE: begin
        if (frame_ok && len_r == PAGE_WRITE_LEN && page_ok) begin
          res_nxt = page[0] ? RES_PROTECTED : RES_OK;
        end
      end
      CODE_PAGE_READ: begin
        rlen_nxt = PAGE_READ_RLEN;
        if (frame_ok && len_r == PARAM_ONLY_LEN && page_ok) begin
          res_nxt  = RES_OK;
          fill_nxt = 1'b0;
        end
      end
      CODE_STATUS: begin
        if (frame_ok && len_r == PARAM_ONLY_LEN && param_r[7:2] == 6'h00) begin
          if (param_r[1:0] == SEL_PROT) begin
            res_nxt  = RES_OK;
            rlen_nxt = STATUS_PROT_RLEN;
          end else if (param_r[1:0] != 2'h3) begin
            res_nxt  = RES_OK;
            rlen_nxt = STATUS_ID_RLEN;
          end
        end
      end
      CODE_SET_ADDR: begin
        if (frame_ok && len_r == PARAM_ONLY_LEN) begin
          if (addr_locked) begin
            res_nxt = RES_PROTECTED;
          end else begin
            res_nxt   = RES_OK;
            take_addr = 1'b1;
          end
        end
      end
      default: begin
        res_nxt = RES_INVALID;
      end
    endcase
  end

  // byte of the reply at position idx_r
  always_comb begin
    tx_byte = 8'h00;
    if (idx_r == 6'h00) begin
      tx_byte = rlen_r;
    end else if (idx_r == 6'h01) begin
      tx_byte = res_r;
    end else if (code_r == CODE_PAGE_READ) begin
      tx_byte = fill_r ? FILL_BYTE : mem_rd;
    end else if (param_r[1:0] == SEL_PROT) begin
      tx_byte = prot_byte(rd_k[2:0]);
    end else if (param_r[1:0] == SEL_MAKER) begin
      tx_byte = (rd_k == 6'h00) ? MAKER_ID[15:8] : MAKER_ID[7:0];
    end else begin
      tx_byte = (rd_k == 6'h00) ? VERSION_ID[15:8] : VERSION_ID[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r     <= D_RX;
      cmd_ready_r <= 1'b1;
      wait_r      <= 16'h0000;
    end else if (ce) begin
      case (state_r)
        D_RX: begin
          if (cmd_hs && lnk.cmd_last) begin
            cmd_ready_r <= 1'b0;
            wait_r      <= duration_cycles((cnt_r == 7'h00) ? lnk.cmd_data : code_r);
            state_r     <= D_EXEC;
          end
        end
        D_EXEC: begin
          // the reply is held back until processing ends, whatever the host does
          if (wait_r != 16'h0000) begin
            wait_r <= wait_r - 16'h0001;
          end else begin
            state_r <= D_TX;
          end
        end
        default: begin
          if (rsp_hs && rsp_last_r) begin
            cmd_ready_r <= 1'b1;
            state_r     <= D_RX;
          end
        end
      endcase
    end
  end

  // frame intake: code, length and first parameter are latched by position
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r   <= 7'h00;
      code_r  <= 8'h00;
      len_r   <= 8'h00;
      param_r <= 8'h00;
    end else if (ce) begin
      if (state_r == D_TX && rsp_hs && rsp_last_r) begin
        cnt_r   <= 7'h00;
        code_r  <= 8'h00;
        len_r   <= 8'h00;
        param_r <= 8'h00;
      end else if (cmd_hs) begin
        if (cnt_r != 7'h7f) begin
          cnt_r <= cnt_r + 7'h01;
        end
        if (cnt_r == 7'h00) begin
          code_r <= lnk.cmd_data;
        end else if (cnt_r == 7'h01) begin
          len_r <= lnk.cmd_data;
        end else if (cnt_r == 7'h02) begin
          param_r <= lnk.cmd_data;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_r  <= RES_INVALID;
      rlen_r <= SHORT_RLEN;
      fill_r <= 1'b1;
    end else if (ce && state_r == D_EXEC && wait_r == 16'h0000) begin
      res_r  <= res_nxt;
      rlen_r <= rlen_nxt;
      fill_r <= fill_nxt;
    end
  end

  // write-once bus address; the lock is only cleared by reset here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_addr    <= DEFAULT_ADDR;
      addr_locked <= 1'b0;
    end else if (ce && state_r == D_EXEC && wait_r == 16'h0000 && take_addr) begin
      dev_addr    <= param_r[7:1];
      addr_locked <= 1'b1;
    end
  end

  // reply stream: one byte offered, taken, then the next one loaded (two cycles a byte)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_r       <= 6'h00;
      rsp_valid_r <= 1'b0;
      rsp_last_r  <= 1'b0;
      rsp_data_r  <= 8'h00;
    end else if (ce) begin
      if (state_r != D_TX) begin
        idx_r       <= 6'h00;
        rsp_valid_r <= 1'b0;
        rsp_last_r  <= 1'b0;
      end else if (!rsp_valid_r) begin
        rsp_valid_r <= 1'b1;
        rsp_data_r  <= tx_byte;
        rsp_last_r  <= tx_last;
      end else if (rsp_hs) begin
        rsp_valid_r <= 1'b0;
        idx_r       <= idx_r + 6'h01;
      end
    end
  end
endmodule // bridge_device

// ===== rtl/bridge_host.sv
// host end: AXI4-Lite register front, frame sender and reply collector
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module bridge_host
  import cmd_bridge_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic      [1:0]  bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             irq,
  cmd_link.host            lnk
);
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT, H_READ} host_state_type;

  host_state_type state_r;
  logic [7:0]  code_r, len_r, param_r, sidx_r, ridx_r, result_r, rlen_r;
  logic [15:0] wait_r;
  logic [4:0]  ptr_r;
  logic [7:0]  buf_r [PAGE_BYTES];
  logic [1:0]  stat_r, mask_r;
  logic        aw_have_r, w_have_r;
  logic [7:0]  waddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        cmd_valid_r, cmd_last_r, rsp_ready_r;
  logic [7:0]  cmd_data_r, nxt_byte, sidx_n, ridx_k;
  logic [31:0] rd_val, cmd_w;
  logic        wr_do, ar_hs, cmd_hs, rsp_hs, rd_hit, wr_hit, start;

  assign lnk.cmd_valid = cmd_valid_r;
  assign lnk.cmd_data  = cmd_data_r;
  assign lnk.cmd_last  = cmd_last_r;
  assign lnk.rsp_ready = rsp_ready_r;

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction

  assign wr_do  = ce && aw_have_r && w_have_r && !bvalid;
  assign ar_hs  = ce && arvalid && arready;
  assign cmd_hs = ce && cmd_valid_r && lnk.cmd_ready;
  assign rsp_hs = ce && rsp_ready_r && lnk.rsp_valid;
  assign cmd_w  = wmerge({16'h0000, len_r, code_r}, wdata_r, wstrb_r);
  // a command write while busy is dropped; software polls busy first
  assign start  = wr_do && waddr_r == REG_CMD && state_r == H_IDLE;
  assign sidx_n = sidx_r + 8'h01;
  assign ridx_k = ridx_r - 8'h02;
  assign wr_hit = (waddr_r == REG_CMD) || (waddr_r == REG_PARAM) || (waddr_r == REG_DATA)
                  || (waddr_r == REG_PTR) || (waddr_r == REG_IRQ_STAT)
                  || (waddr_r == REG_IRQ_MASK);

  // frame order: code, length, parameter, then data from the buffer
  always_comb begin
    if (sidx_n == 8'h01) begin
      nxt_byte = len_r;
    end else if (sidx_n == 8'h02) begin
      nxt_byte = param_r;
    end else begin
      nxt_byte = buf_r[5'(sidx_n - 8'h03)];
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (araddr == REG_CMD) begin
      rd_val = {16'h0000, len_r, code_r};
    end else if (araddr == REG_PARAM) begin
      rd_val = {24'h000000, param_r};
    end else if (araddr == REG_DATA) begin
      rd_val = {24'h000000, buf_r[ptr_r]};
    end else if (araddr == REG_PTR) begin
      rd_val = {27'h0, ptr_r};
    end else if (araddr == REG_STATUS) begin
      rd_val = {8'h00, rlen_r, result_r, 7'h00, state_r != H_IDLE};
    end else if (araddr == REG_IRQ_STAT) begin
      rd_val = {30'h0, stat_r};
    end else if (araddr == REG_IRQ_MASK) begin
      rd_val = {30'h0, mask_r};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // write channels are taken in either order, answered once both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      waddr_r   <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awready   <= 1'b0;
        aw_have_r <= 1'b1;
        waddr_r   <= awaddr;
      end
      if (wvalid && wready) begin
        wready   <= 1'b0;
        w_have_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end
      if (wr_do) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (ar_hs) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_val;
        rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      param_r <= 8'h00;
      mask_r  <= 2'h0;
    end else if (wr_do) begin
      if (waddr_r == REG_PARAM) begin
        param_r <= 8'(wmerge({24'h000000, param_r}, wdata_r, wstrb_r));
      end else if (waddr_r == REG_IRQ_MASK) begin
        mask_r <= 2'(wmerge({30'h0, mask_r}, wdata_r, wstrb_r));
      end
    end
  end

  // buffer pointer steps after every data access, so pages stream through one word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_r <= 5'h00;
    end else if (wr_do && waddr_r == REG_PTR) begin
      ptr_r <= 5'(wmerge({27'h0, ptr_r}, wdata_r, wstrb_r));
    end else if ((wr_do && waddr_r == REG_DATA) || (ar_hs && araddr == REG_DATA)) begin
      ptr_r <= ptr_r + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (ce && state_r == H_READ && rsp_hs && ridx_r >= 8'h02 && ridx_k < 8'(PAGE_BYTES)) begin
      buf_r[ridx_k[4:0]] <= lnk.rsp_data;
    end else if (wr_do && waddr_r == REG_DATA && wstrb_r[0]) begin
      buf_r[ptr_r] <= wdata_r[7:0];
    end
  end

  // done and error flags: a new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= 2'h0;
      irq    <= 1'b0;
    end else if (ce) begin
      stat_r <= (stat_r & ~((wr_do && waddr_r == REG_IRQ_STAT && wstrb_r[0]) ?
                            wdata_r[1:0] : 2'h0))
                | {2{rsp_hs && lnk.rsp_last}} & {ridx_r == 8'h01 ? lnk.rsp_data != RES_OK
                                                  : result_r != RES_OK, 1'b1};
      irq <= |(stat_r & mask_r);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r     <= H_IDLE;
      code_r      <= 8'h00;
      len_r       <= 8'h00;
      sidx_r      <= 8'h00;
      ridx_r      <= 8'h00;
      wait_r      <= 16'h0000;
      result_r    <= 8'h00;
      rlen_r      <= 8'h00;
      cmd_valid_r <= 1'b0;
      cmd_last_r  <= 1'b0;
      cmd_data_r  <= 8'h00;
      rsp_ready_r <= 1'b0;
    end else if (ce) begin
      case (state_r)
        H_IDLE: begin
          if (start) begin
            code_r      <= cmd_w[7:0];
            len_r       <= cmd_w[15:8];
            sidx_r      <= 8'h00;
            cmd_data_r  <= cmd_w[7:0];
            cmd_valid_r <= 1'b1;
            cmd_last_r  <= 1'b0;
            state_r     <= H_SEND;
          end
        end
        H_SEND: begin
          if (cmd_hs && cmd_last_r) begin
            cmd_valid_r <= 1'b0;
            cmd_last_r  <= 1'b0;
            wait_r      <= duration_cycles(code_r);
            state_r     <= H_WAIT;
          end else if (cmd_hs) begin
            sidx_r     <= sidx_n;
            cmd_data_r <= nxt_byte;
            cmd_last_r <= sidx_n == len_r + 8'h01;
          end
        end
        H_WAIT: begin
          if (wait_r != 16'h0000) begin
            wait_r <= wait_r - 16'h0001;
          end else begin
            ridx_r      <= 8'h00;
            rsp_ready_r <= 1'b1;
            state_r     <= H_READ;
          end
        end
        default: begin
          if (rsp_hs) begin
            ridx_r <= ridx_r + 8'h01;
            if (ridx_r == 8'h00) begin
              rlen_r <= lnk.rsp_data;
            end else if (ridx_r == 8'h01) begin
              result_r <= lnk.rsp_data;
            end
            if (lnk.rsp_last) begin
              rsp_ready_r <= 1'b0;
              state_r     <= H_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule // bridge_host

// ===== test/cmd_monitor.sv
// link checker: handshakes, reply framing, reply length codes and fill bytes
`timescale 1ns/1ps
module cmd_monitor (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic [7:0] cmd_data,
  input wire logic       cmd_last,
  input wire logic       rsp_valid,
  input wire logic       rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_last
);
  logic [7:0] idx_r, len_r, res_r;
  wire        tk  = rsp_valid && rsp_ready;
  wire        fin = cmd_valid && cmd_ready && cmd_last;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // index restarts on every last byte, so a cut reply cannot skew the next
  always_ff @(posedge aclk) begin
    if (!aresetn || (tk && rsp_last)) idx_r <= 8'h00;
    else if (tk) idx_r <= idx_r + 8'h01;
  end
  always_ff @(posedge aclk) begin
    if (tk && idx_r == 8'h00) len_r <= rsp_data;
    if (tk && idx_r == 8'h01) res_r <= rsp_data;
  end
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("reply byte moved");
  a_rsp_gap: assert property (tk |=> !rsp_valid)
    else $error("no gap after reply byte");
  a_frame_end: assert property (fin |=> !cmd_ready)
    else $error("ready after frame end");
  a_no_overlap: assert property (rsp_valid |-> !cmd_ready)
    else $error("ready during reply");
  a_proc_wait: assert property (fin |=> !rsp_valid [*8])
    else $error("reply too early");
  a_len_code: assert property (
    rsp_valid && idx_r == 8'h00 |-> rsp_data inside {8'h01, 8'h03, 8'h07, 8'h21})
    else $error("bad reply length");
  a_last_pos: assert property (
    rsp_valid && idx_r != 8'h00 |-> rsp_last == (idx_r == len_r))
    else $error("last byte misplaced");
  a_fill_ff: assert property (
    rsp_valid && idx_r > 8'h01 && res_r == 8'h77 |-> rsp_data == 8'hff)
    else $error("fill byte wrong");
  c_frame: cover property (fin);
  c_page: cover property (tk && rsp_last && len_r == 8'h21);
  c_fill: cover property (tk && idx_r > 8'h01 && res_r == 8'h77);
endmodule // cmd_monitor

// ===== test/tb.sv
// bench: both link ends driven through the register bus
`timescale 1ns/1ps
module tb
  import cmd_bridge_pkg::*;
();
  localparam logic [15:0] MK = 16'hc3a5, VR = 16'h0e17; // arbitrary values
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, addr_locked;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [1:0]  bresp, rresp;
  logic [6:0]  dev_addr;
  int          err_count = 0;
  int          n_tests = 0;
  cmd_link lnk();
  bridge_host bridge_host_inst(.aclk, .aresetn, .ce(1'b1), .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .irq, .lnk(lnk.host));
  // page 2 carries the lock so both protection bits show up
  bridge_device #(.MAKER_ID(MK), .VERSION_ID(VR), .NONE_LOCK(6'h04)) bridge_device_inst(
    .aclk, .aresetn, .ce(1'b1), .lnk(lnk.device), .dev_addr, .addr_locked);
  cmd_monitor cmd_monitor_inst(.aclk, .aresetn, .cmd_valid(lnk.cmd_valid),
    .cmd_ready(lnk.cmd_ready), .cmd_data(lnk.cmd_data), .cmd_last(lnk.cmd_last),
    .rsp_valid(lnk.rsp_valid), .rsp_ready(lnk.rsp_ready), .rsp_data(lnk.rsp_data),
    .rsp_last(lnk.rsp_last));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one bus access; w selects write, read data lands in q
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, araddr, wdata} <= {a, a, d};
    {awvalid, wvalid, bready} <= {3{w}};
    {arvalid, rready} <= {2{!w}};
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end while (!(w ? bvalid === 1'b1 : rvalid === 1'b1));
    q = w ? {30'h0, bresp} : rdata;
    {bready, rready} <= 2'b00;
  endtask
  task automatic go(input logic [7:0] c, l, p, input logic [15:0] e);
    int k;
    k = 0;
    acc(1'b1, REG_PARAM, {24'h0, p});
    acc(1'b1, REG_CMD, {16'h0, l, c});
    do begin
      acc(1'b0, REG_STATUS, 32'h0);
      k++;
    end while (q[0] !== 1'b0 && k < 400);
    chk("busy", {31'h0, q[0]}, 32'h0);
    chk("result", {16'h0, q[23:8]}, {16'h0, e});
    acc(1'b1, REG_PTR, 32'h0);
  endtask
  task automatic final_report;
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    #1000000;
    err_count++;
    final_report();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    acc(1'b0, 8'h40, 32'h0);
    chk("unmapped", {30'h0, rresp}, {30'h0, RESP_SLVERR});
    acc(1'b1, 8'h40, 32'h0);
    chk("unmapped_w", q, {30'h0, RESP_SLVERR});
    chk("addr0", {24'h0, addr_locked, dev_addr}, {25'h0, DEFAULT_ADDR_RST});
    acc(1'b1, REG_IRQ_MASK, 32'h3);
    acc(1'b1, REG_PTR, 32'h0);
    for (int i = 0; i < 32; i++) acc(1'b1, REG_DATA, 32'(i * 7 + 3));
    go(CODE_PAGE_WRITE, PAGE_WRITE_LEN, 8'h00, {SHORT_RLEN, RES_OK});
    go(CODE_PAGE_WRITE, PAGE_WRITE_LEN, 8'h01, {SHORT_RLEN, RES_PROTECTED});
    go(CODE_PAGE_READ, PARAM_ONLY_LEN, 8'h00, {PAGE_READ_RLEN, RES_OK});
    for (int i = 0; i < 32; i++) begin
      acc(1'b0, REG_DATA, 32'h0);
      chk("page0", q & 32'hff, {24'h0, 8'(i * 7 + 3)});
    end
    go(CODE_PAGE_READ, PARAM_ONLY_LEN, 8'h03, {PAGE_READ_RLEN, RES_OK});
    go(CODE_PAGE_READ, PARAM_ONLY_LEN, 8'h06, {PAGE_READ_RLEN, RES_INVALID});
    for (int i = 0; i < 32; i++) begin
      acc(1'b0, REG_DATA, 32'h0);
      chk("fill", q & 32'hff, 32'hff);
    end
    chk("irq_on", {31'h0, irq}, 32'h1);
    acc(1'b1, REG_IRQ_STAT, 32'h3);
    acc(1'b0, REG_IRQ_STAT, 32'h0);
    chk("irq_off", {31'h0, irq}, 32'h0);
    go(CODE_STATUS, PARAM_ONLY_LEN, 8'h00, {STATUS_PROT_RLEN, RES_OK});
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, REG_DATA, 32'h0);
      chk("prot", q & 32'hff, i[0] ? 32'h02 : (i == 2 ? 32'h20 : 32'h00));
    end
    go(CODE_STATUS, PARAM_ONLY_LEN, 8'h01, {STATUS_ID_RLEN, RES_OK});
    for (int j = 0; j < 2; j++) begin
      acc(1'b0, REG_DATA, 32'h0);
      chk("maker", q & 32'hff, {24'h0, MK[15 - 8 * j -: 8]});
    end
    go(CODE_STATUS, PARAM_ONLY_LEN, 8'h02, {STATUS_ID_RLEN, RES_OK});
    for (int j = 0; j < 2; j++) begin
      acc(1'b0, REG_DATA, 32'h0);
      chk("version", q & 32'hff, {24'h0, VR[15 - 8 * j -: 8]});
    end
    go(CODE_STATUS, PARAM_ONLY_LEN, 8'h03, {SHORT_RLEN, RES_INVALID});
    go(CODE_SET_ADDR, PARAM_ONLY_LEN, 8'h85, {SHORT_RLEN, RES_OK});
    chk("addr1", {24'h0, addr_locked, dev_addr}, 32'hc2);
    go(CODE_SET_ADDR, PARAM_ONLY_LEN, 8'h10, {SHORT_RLEN, RES_PROTECTED});
    chk("addr2", {24'h0, addr_locked, dev_addr}, 32'hc2);
    final_report();
  end
endmodule // tb
